// ### core/apr_readout.sv
/*
  absolute position readout sequencer with four channel position registers.
  assumes link inputs synchronous to clk and a strobe-style register port.
*/
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module apr_readout
  import apr_pkg::*;
#(
  parameter int SETUP_CYC = APR_SETUP_CYC,
  parameter int TIMEOUT_CYC = APR_TIMEOUT_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // activation
  input wire logic activate,
  // amplifier link
  input wire apr_in_t link_in,
  output apr_out_t link_out,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flags
  output logic execution_done_flag,
  output logic timeout_flag
);
  localparam int STEP_W = $clog2(APR_STEPS + 1);
  localparam int TMR_W = $clog2(TIMEOUT_CYC + SETUP_CYC + 2);
  localparam int WORD_W = APR_POS_BITS + APR_EXTRA_BITS;

  apr_state_t state_r, state_nxt;
  logic [STEP_W-1:0] step_r;
  logic [TMR_W-1:0] tmr_r;
  logic [31:0] pos_r [0:3];
  logic [1:0] dest_r;
  logic sw_run_r;
  logic done_r;
  logic tmo_r;
  logic [31:0] rdata_r;
  logic [WORD_W-1:0] word;
  logic run;
  logic sample;
  logic last_step;
  logic tmr_hit;

  // software run bit and the pin both count as activation
  assign run = activate | sw_run_r;
  assign sample = (state_r == APR_REQ) && link_in.ready;
  assign last_step = (step_r == STEP_W'(APR_STEPS - 1));
  assign tmr_hit = (tmr_r >= TMR_W'(TIMEOUT_CYC));

  apr_shift #(.WIDTH(WORD_W)) apr_shift_i (
    .clk(clk),
    .rst(rst),
    .clear(state_r == APR_SETUP),
    .load(sample),
    .pair({link_in.bit1, link_in.bit0}),
    .word(word)
  );

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      APR_IDLE: if (run) state_nxt = APR_SETUP;
      APR_SETUP: if (tmr_r >= TMR_W'(SETUP_CYC - 1)) state_nxt = APR_REQ;
      APR_REQ:
      begin
        if (sample) state_nxt = APR_RELEASE;
        else if (tmr_hit) state_nxt = APR_FAIL;
      end
      APR_RELEASE:
      begin
        if (!link_in.ready) state_nxt = last_step ? APR_DONE : APR_REQ;
        else if (tmr_hit) state_nxt = APR_FAIL;
      end
      APR_DONE: state_nxt = APR_DONE;
      APR_FAIL: state_nxt = APR_FAIL;
      default: state_nxt = APR_IDLE;
    endcase
    if (!run) state_nxt = APR_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_r <= APR_IDLE;
    else
      state_r <= state_nxt;
  end

  // timer restarts on each state change so it bounds every handshake edge
  always_ff @(posedge clk)
  begin
    if (rst || state_r != state_nxt)
      tmr_r <= '0;
    else if (!tmr_hit)
      tmr_r <= tmr_r + TMR_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_r == APR_IDLE)
      step_r <= '0;
    else if (state_r == APR_RELEASE && !link_in.ready)
      step_r <= step_r + STEP_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      link_out <= '0;
    else
    begin
      link_out.servo_on <= (state_nxt != APR_IDLE);
      link_out.xfer_mode <= (state_nxt != APR_IDLE) && (state_nxt != APR_DONE);
      link_out.request <= (state_nxt == APR_REQ) && (state_r != APR_SETUP
        || tmr_r >= TMR_W'(SETUP_CYC - 1));
    end
  end

  // done and timeout stay set while activation holds; dropping activation clears them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_r <= 1'b0;
      tmo_r <= 1'b0;
    end
    else
    begin
      done_r <= (state_nxt == APR_DONE);
      tmo_r <= (state_nxt == APR_FAIL);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sw_run_r <= 1'b0;
      dest_r <= 2'h0;
    end
    else if (reg_wr && reg_addr == APR_ADDR_CTRL)
    begin
      sw_run_r <= reg_wdata[APR_CTRL_RUN];
      dest_r <= reg_wdata[APR_CTRL_DEST_LO +: 2];
    end
  end

  // hardware store on completion wins over a software write in the same cycle
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_pos
      always_ff @(posedge clk)
      begin
        if (rst)
          pos_r[ch] <= APR_POS_RESET;
        else if (state_r == APR_RELEASE && state_nxt == APR_DONE && dest_r == 2'(ch))
          pos_r[ch] <= word[APR_POS_BITS-1:0];
        else if (reg_wr && reg_addr == 4'(ch))
          pos_r[ch] <= reg_wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_r <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        APR_ADDR_CH0, APR_ADDR_CH1, APR_ADDR_CH2, APR_ADDR_CH3: rdata_r <= pos_r[reg_addr[1:0]];
        APR_ADDR_CTRL: rdata_r <= {29'h0, dest_r, sw_run_r};
        APR_ADDR_STAT: rdata_r <= {29'h0, (state_r != APR_IDLE), tmo_r, done_r};
        APR_ADDR_RAW: rdata_r <= {26'h0, word[WORD_W-1:APR_POS_BITS]};
        default: rdata_r <= '0;
      endcase
    end
    else
      rdata_r <= '0;
  end

  assign reg_rdata = rdata_r;
  assign execution_done_flag = done_r;
  assign timeout_flag = tmo_r;

  chk_servo_follows_run: assert property (@(posedge clk) disable iff (rst)
    !run |=> !link_out.servo_on) else $error("servo-on not dropped");
  chk_mode_before_req: assert property (@(posedge clk) disable iff (rst)
    $rose(link_out.request) |-> link_out.servo_on && link_out.xfer_mode)
    else $error("request before mode");
  chk_abort_on_drop: assert property (@(posedge clk) disable iff (rst)
    !run |=> state_r == APR_IDLE && !link_out.request) else $error("no abort");
  chk_done_after_steps: assert property (@(posedge clk) disable iff (rst)
    $rose(done_r) |-> $past(step_r) == STEP_W'(APR_STEPS - 1)) else $error("early done");
  chk_req_drops_sample: assert property (@(posedge clk) disable iff (rst)
    sample && run |=> !link_out.request) else $error("request held after sample");
  chk_step_bound: assert property (@(posedge clk) disable iff (rst)
    step_r <= STEP_W'(APR_STEPS)) else $error("step overflow");
  chk_store_done: assert property (@(posedge clk) disable iff (rst)
    $rose(done_r) |-> pos_r[dest_r] == word[APR_POS_BITS-1:0]) else $error("not stored");
  chk_timeout_flag: assert property (@(posedge clk) disable iff (rst)
    $rose(tmo_r) |-> $past(tmr_hit)) else $error("timeout without wait");
endmodule : apr_readout
`default_nettype wire

// ### include/apr_pkg.sv
/*
  constants and types for the absolute position readout block.
  assumes one 100 MHz clock and a synchronous active-high reset.
*/
// What this block does
// - inputs are three bits: data bit 0, data bit 1, send-data-ready.
// - outputs are three bits: servo-on, transfer mode, data request.
// - on activation assert servo-on and transfer mode before any exchange.
// - transfer 32 plus 6 bits, each step paced by request/ready handshake.
// - store the received position as one 32-bit value at the chosen destination.
// - the value written is already a pulse count.
// - set the execution done flag when the whole value has been read.
// - withdrawing activation during reading aborts the readout.
// - servo-on stays asserted only while activation remains.
// - handshake failure raises no error itself; a timeout monitors it.
package apr_pkg;
  localparam int APR_POS_BITS = 32;
  localparam int APR_EXTRA_BITS = 6;
  localparam int APR_STEPS = (APR_POS_BITS + APR_EXTRA_BITS) / 2;
  localparam int APR_CLK_MHZ = 100;
  localparam int APR_SETUP_US = 1;
  localparam int APR_SETUP_CYC = APR_SETUP_US * APR_CLK_MHZ;
  localparam int APR_TIMEOUT_MS = 100;
  localparam int APR_TIMEOUT_CYC = APR_TIMEOUT_MS * 1000 * APR_CLK_MHZ;
  localparam logic [3:0] APR_ADDR_CH0 = 4'h0;
  localparam logic [3:0] APR_ADDR_CH1 = 4'h1;
  localparam logic [3:0] APR_ADDR_CH2 = 4'h2;
  localparam logic [3:0] APR_ADDR_CH3 = 4'h3;
  localparam logic [3:0] APR_ADDR_CTRL = 4'h4;
  localparam logic [3:0] APR_ADDR_STAT = 4'h5;
  localparam logic [3:0] APR_ADDR_RAW = 4'h6;
  localparam int APR_CTRL_RUN = 0;
  localparam int APR_CTRL_DEST_LO = 1;
  localparam int APR_STAT_DONE = 0;
  localparam int APR_STAT_TMO = 1;
  localparam int APR_STAT_BUSY = 2;
  localparam logic [31:0] APR_POS_RESET = 32'h0000_0000;

  typedef struct packed {
    logic ready;
    logic bit1;
    logic bit0;
  } apr_in_t;

  typedef struct packed {
    logic request;
    logic xfer_mode;
    logic servo_on;
  } apr_out_t;

  typedef enum logic [2:0] {
    APR_IDLE = 3'b000,
    APR_SETUP = 3'b001,
    APR_REQ = 3'b010,
    APR_RELEASE = 3'b011,
    APR_DONE = 3'b100,
    APR_FAIL = 3'b101
  } apr_state_t;
endpackage : apr_pkg

// ### core/apr_shift.sv
/*
  two-bit step assembler for the position word, lsb first.
  assumes the sequencer pulses load only while the data lines are valid.
*/
`timescale 1ns/1ps
`default_nettype none
module apr_shift
  import apr_pkg::*;
#(
  parameter int WIDTH = APR_POS_BITS + APR_EXTRA_BITS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic load,
  input wire logic [1:0] pair,
  // result
  output logic [WIDTH-1:0] word
);
  logic [WIDTH-1:0] word_r;

  // new pairs enter at the top so the first pair ends at bit 0
  always_ff @(posedge clk)
  begin
    if (rst || clear)
      word_r <= '0;
    else if (load)
      word_r <= {pair, word_r[WIDTH-1:2]};
  end

  assign word = word_r;
endmodule : apr_shift
`default_nettype wire

// ### verif/apr_amp_model.sv
/*
  behavioural amplifier model: answers the request/ready handshake two bits a step.
  assumes the readout drives link_out on clk; delay slows it, stall silences it.
*/
`timescale 1ns/1ps
`default_nettype none
module apr_amp_model
  import apr_pkg::*;
(
  // controls from the bench
  input wire logic clk,
  input wire logic stall,
  input wire logic [5:0] delay,
  input wire logic [37:0] word,
  // link
  input wire apr_out_t link_out,
  output var apr_in_t link_in
);
  int step = 0;
  int wait_n = 0;
  initial link_in = 3'b011;
  always @(posedge clk)
  begin
    if (!link_out.xfer_mode)
    begin
      step <= 0;
      wait_n <= 0;
      link_in.ready <= 1'b0;
    end
    else if (!stall && link_out.request != link_in.ready)
    begin
      if (wait_n < delay)
        wait_n <= wait_n + 1;
      else if (link_out.request)
      begin
        wait_n <= 0;
        link_in.bit0 <= word[2*step];
        link_in.bit1 <= word[2*step+1];
        link_in.ready <= 1'b1;
      end
      else
      begin
        wait_n <= 0;
        step <= step + 1;
        // released lines flip so stale data never looks valid
        link_in.bit0 <= ~link_in.bit0;
        link_in.bit1 <= ~link_in.bit1;
        link_in.ready <= 1'b0;
      end
    end
  end
endmodule : apr_amp_model
`default_nettype wire

// ### verif/apr_readout_test.sv
/*
  testbench for apr_readout: register tasks and readout runs.
  assumes the amplifier model apr_amp_model on the link.
*/
`timescale 1ns/1ps
`default_nettype none
module apr_readout_test
  import apr_pkg::*;
;
  localparam logic [37:0] WORD = 38'h2D_A5C3_0F96;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic activate = 1'b0;
  logic stall = 1'b0;
  logic [5:0] delay = 6'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic done;
  logic tmo;
  apr_in_t link_in;
  apr_out_t link_out;
  int n_mismatch = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  // short counts keep the run brief
  apr_readout #(.SETUP_CYC(4), .TIMEOUT_CYC(50)) apr_readout_i (.clk(clk), .rst(rst),
    .activate(activate), .link_in(link_in), .link_out(link_out), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .execution_done_flag(done), .timeout_flag(tmo));
  apr_amp_model apr_amp_model_i (.clk(clk), .stall(stall), .delay(delay), .word(WORD),
    .link_out(link_out), .link_in(link_in));

  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask : rd

  task wait_flag();
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      if (done === 1'b1 || tmo === 1'b1)
        return;
    end
    n_mismatch++;
    end_sim();
  endtask : wait_flag

  // sw selects the software run bit instead of the activation pin
  task run(input logic [1:0] dest, input logic [5:0] dl, input logic sw);
    delay <= dl;
    wr(APR_ADDR_CTRL, {29'h0, dest, sw});
    @(posedge clk);
    activate <= !sw;
    repeat (3) @(posedge clk);
    #1 cmp({29'h0, link_out}, 32'h3);
    wait_flag();
    #1 cmp({31'h0, done}, 32'h1);
    cmp({29'h0, link_out}, 32'h1);
    rd({2'h0, dest}, WORD[31:0]);
    rd(APR_ADDR_RAW, {26'h0, WORD[37:32]});
    // busy stays up in the done state until activation drops
    rd(APR_ADDR_STAT, 32'h5);
    rd(APR_ADDR_CTRL, {29'h0, dest, sw});
    if (sw)
      wr(APR_ADDR_CTRL, {29'h0, dest, 1'b0});
    else
    begin
      @(posedge clk);
      activate <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1 cmp({29'h0, link_out}, 32'h0);
    cmp({31'h0, done}, 32'h0);
  endtask : run

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // words 0 to 7, the unmapped word 7 too, read zero after reset
    for (int i = 0; i < 8; i++)
      rd(i[3:0], 32'h0);
    wr(APR_ADDR_CH3, 32'h1234_5678);
    rd(APR_ADDR_CH3, 32'h1234_5678);
    run(2'h2, 6'h00, 1'b0);
    run(2'h0, 6'h05, 1'b0);
    run(2'h3, 6'h01, 1'b1);
    // abort in mid transfer
    delay <= 6'h02;
    wr(APR_ADDR_CTRL, 32'h2);
    @(posedge clk);
    activate <= 1'b1;
    repeat (40) @(posedge clk);
    activate <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp({29'h0, link_out}, 32'h0);
    rd(APR_ADDR_CH1, 32'h0);
    rd(APR_ADDR_STAT, 32'h0);
    // silent amplifier
    stall <= 1'b1;
    @(posedge clk);
    activate <= 1'b1;
    wait_flag();
    #1 cmp({31'h0, tmo}, 32'h1);
    cmp({30'h0, done, link_out.request}, 32'h0);
    rd(APR_ADDR_STAT, 32'h6);
    @(posedge clk);
    activate <= 1'b0;
    stall <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp({31'h0, tmo}, 32'h0);
    end_sim();
  end
endmodule : apr_readout_test
`default_nettype wire
